//--- rtl/cprg_regs.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Two-flop synchroniser
// ------------------------------------------------------------------
module cprg_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } cprg_sync_state_s;
  cprg_sync_state_s st_r;
  cprg_sync_state_s st_nxt;
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign q_o = st_r.s2;
endmodule

// ------------------------------------------------------------------
// Link-clock side: takes slot commands, returns answers
// ------------------------------------------------------------------
module cprg_link_port (
  // Clock and reset
  input  wire logic                       link_clk_i,
  input  wire logic                       rst_b_i,
  // Slot command and answer
  input  wire logic                       slot_cmd_valid_i,
  input  wire cprg_pkg::cprg_cmd_s        slot_cmd_i,
  output logic                            slot_rsp_valid_o,
  output logic [cprg_pkg::DATA_W-1:0]     slot_rsp_data_o,
  output logic                            codec_ready_o,
  // Crossing to core
  output logic                            req_tgl_o,
  output cprg_pkg::cprg_cmd_s             cmd_o,
  input  wire logic                       ack_tgl_i,
  input  wire logic [cprg_pkg::DATA_W-1:0] rdata_i,
  input  wire logic                       core_ready_i
);
  typedef struct packed {
    cprg_pkg::cprg_cmd_s         cmd;
    logic                        req_tgl;
    logic                        ack_seen;
    logic                        rsp_valid;
    logic [cprg_pkg::DATA_W-1:0] rsp_data;
  } cprg_link_state_s;
  cprg_link_state_s st_r;
  cprg_link_state_s st_nxt;
  logic [1:0]       xs;
  logic             busy;
  cprg_sync #(.W(2)) u_sync (
    .clk_i   (link_clk_i),
    .rst_b_i (rst_b_i),
    .d_i     ({ack_tgl_i, core_ready_i}),
    .q_o     (xs)
  );
  assign busy = (st_r.req_tgl != st_r.ack_seen);
  always_comb begin
    st_nxt           = st_r;
    st_nxt.rsp_valid = 1'b0;
    // Command is held steady until the core answers, so the word crosses safely
    if (slot_cmd_valid_i && !busy && xs[0]) begin
      st_nxt.cmd     = slot_cmd_i;
      st_nxt.req_tgl = ~st_r.req_tgl;
    end
    if (xs[1] != st_r.ack_seen) begin
      st_nxt.ack_seen  = xs[1];
      st_nxt.rsp_valid = 1'b1;
      st_nxt.rsp_data  = rdata_i;
    end
  end
  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign req_tgl_o        = st_r.req_tgl;
  assign cmd_o            = st_r.cmd;
  assign slot_rsp_valid_o = st_r.rsp_valid;
  assign slot_rsp_data_o  = st_r.rsp_data;
  assign codec_ready_o    = xs[0];
endmodule

// ------------------------------------------------------------------
// Register bank, core clock side
// ------------------------------------------------------------------
module cprg_regs (
  // Clocks and reset
  input  wire logic                         core_clk_i,
  input  wire logic                         link_clk_i,
  input  wire logic                         rst_b_i,
  // Register slots, link clock
  input  wire logic                         slot_cmd_valid_i,
  input  wire cprg_pkg::cprg_cmd_s          slot_cmd_i,
  output logic                              slot_rsp_valid_o,
  output logic [cprg_pkg::DATA_W-1:0]       slot_rsp_data_o,
  output logic                              codec_ready_o,
  // Subsystem readiness, asynchronous
  input  wire logic                         bias_ready_i,
  input  wire logic                         playback_ready_i,
  input  wire logic                         record_ready_i,
  // Power-down controls
  output logic                              internal_clock_off_o,
  output logic                              link_powerdown_o,
  output logic                              audio_bias_powerdown_o,
  output logic                              playback_path_powerdown_o,
  output logic                              record_path_powerdown_o,
  // Sample rates
  output logic                              variable_rate_enable_o,
  output logic [cprg_pkg::DATA_W-1:0]       playback_rate_value_o,
  output logic [cprg_pkg::DATA_W-1:0]       record_rate_value_o,
  // General-purpose pins
  input  wire logic [cprg_pkg::GPIO_W-1:0]  gpio_pin_bits_i,
  output logic      [cprg_pkg::GPIO_W-1:0]  gpio_pin_bits_o,
  output logic      [cprg_pkg::GPIO_W-1:0]  gpio_output_bits_o,
  // Event sources, asynchronous
  input  wire logic                         overflow_signal_i,
  input  wire logic                         clipping_signal_i,
  input  wire logic                         touch_minus_comparator_i,
  input  wire logic                         touch_plus_comparator_i,
  input  wire logic                         conversion_done_i
);
  localparam int XW = 1 + cprg_pkg::GPIO_W + cprg_pkg::SRC_W + cprg_pkg::STS_W;

  typedef struct packed {
    logic [3:0]                  init_cnt;
    logic                        ready;
    logic                        req_seen;
    logic                        ack_tgl;
    logic [cprg_pkg::DATA_W-1:0] rdata;
    logic [cprg_pkg::DATA_W-1:0] pd_ctrl;
    logic                        var_rate;
    logic [cprg_pkg::DATA_W-1:0] dac_rate;
    logic [cprg_pkg::DATA_W-1:0] adc_rate;
    logic [cprg_pkg::GPIO_W-1:0] gpio_out;
    logic [cprg_pkg::GPIO_W-1:0] gpio_dir;
    logic [cprg_pkg::DATA_W-1:0] rise_en;
    logic [cprg_pkg::DATA_W-1:0] fall_en;
    logic [cprg_pkg::DATA_W-1:0] irq_stat;
    logic [cprg_pkg::DATA_W-1:0] evt_prev;
  } cprg_core_state_s;

  cprg_core_state_s            st_r;
  cprg_core_state_s            st_nxt;
  cprg_pkg::cprg_cmd_s         cmd;
  logic                        req_tgl;
  logic [XW-1:0]               xs;
  logic                        req_s;
  logic [cprg_pkg::GPIO_W-1:0] pins_s;
  logic [cprg_pkg::SRC_W-1:0]  src_s;
  logic [cprg_pkg::STS_W-1:0]  sts_s;
  logic                        fire;
  logic                        wr;
  logic [cprg_pkg::DATA_W-1:0] evt_now;
  logic [cprg_pkg::DATA_W-1:0] hits;
  logic [cprg_pkg::DATA_W-1:0] pd_word;
  logic [cprg_pkg::DATA_W-1:0] dac_eff;
  logic [cprg_pkg::DATA_W-1:0] adc_eff;
  logic [cprg_pkg::DATA_W-1:0] rd_word;

  // ----------------------------------------------------------------
  // Link side and crossings
  // ----------------------------------------------------------------
  cprg_link_port u_link (
    .link_clk_i       (link_clk_i),
    .rst_b_i          (rst_b_i),
    .slot_cmd_valid_i (slot_cmd_valid_i),
    .slot_cmd_i       (slot_cmd_i),
    .slot_rsp_valid_o (slot_rsp_valid_o),
    .slot_rsp_data_o  (slot_rsp_data_o),
    .codec_ready_o    (codec_ready_o),
    .req_tgl_o        (req_tgl),
    .cmd_o            (cmd),
    .ack_tgl_i        (st_r.ack_tgl),
    .rdata_i          (st_r.rdata),
    .core_ready_i     (st_r.ready)
  );

  cprg_sync #(.W(XW)) u_sync (
    .clk_i   (core_clk_i),
    .rst_b_i (rst_b_i),
    .d_i     ({req_tgl, gpio_pin_bits_i, overflow_signal_i, clipping_signal_i,
                touch_minus_comparator_i, touch_plus_comparator_i, conversion_done_i,
                bias_ready_i, playback_ready_i, record_ready_i}),
    .q_o     (xs)
  );

  assign {req_s, pins_s, src_s, sts_s} = xs;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    pd_word                        = st_r.pd_ctrl & cprg_pkg::PD_CTRL_MASK;
    pd_word[cprg_pkg::ST_REF]      = sts_s[2];
    pd_word[cprg_pkg::ST_DAC]      = sts_s[1];
    pd_word[cprg_pkg::ST_ADC]      = sts_s[0];
  end

  // Rate outputs hold 48000 whenever variable rate is off
  assign dac_eff = st_r.var_rate ? st_r.dac_rate : cprg_pkg::RATE_RESET;
  assign adc_eff = st_r.var_rate ? st_r.adc_rate : cprg_pkg::RATE_RESET;

  always_comb begin
    rd_word = '0;
    case (cmd.index)
      cprg_pkg::IDX_PWR:       rd_word = pd_word;
      cprg_pkg::IDX_EXT_ID:    rd_word = cprg_pkg::EXT_ID_VALUE;
      cprg_pkg::IDX_EXT_CTRL:  rd_word[cprg_pkg::VR_BIT] = st_r.var_rate;
      cprg_pkg::IDX_DAC_RATE:  rd_word = dac_eff;
      cprg_pkg::IDX_ADC_RATE:  rd_word = adc_eff;
      cprg_pkg::IDX_GPIO_DATA: rd_word[cprg_pkg::GPIO_W-1:0] = pins_s;
      cprg_pkg::IDX_GPIO_DIR:  rd_word[cprg_pkg::GPIO_W-1:0] = st_r.gpio_dir;
      cprg_pkg::IDX_RISE_EN:   rd_word = st_r.rise_en;
      cprg_pkg::IDX_FALL_EN:   rd_word = st_r.fall_en;
      cprg_pkg::IDX_IRQ_STAT:  rd_word = st_r.irq_stat;
      default:                 rd_word = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  assign evt_now = {src_s, 1'b0, pins_s};
  // Only the synchronised copy is compared, never the first flop
  assign hits = ((evt_now & ~st_r.evt_prev & st_r.rise_en) |
                 (~evt_now & st_r.evt_prev & st_r.fall_en)) & cprg_pkg::IRQ_MASK;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  assign fire = st_r.ready && (req_s != st_r.req_seen);
  assign wr   = fire && cmd.write;

  always_comb begin
    st_nxt          = st_r;
    st_nxt.evt_prev = evt_now;
    if (!st_r.ready) begin
      st_nxt.init_cnt = st_r.init_cnt + 4'h1;
      if (st_r.init_cnt == cprg_pkg::INIT_CYCLES - 4'h1) begin
        st_nxt.ready = 1'b1;
      end
    end
    if (fire) begin
      st_nxt.req_seen = req_s;
      st_nxt.ack_tgl  = ~st_r.ack_tgl;
      st_nxt.rdata    = cmd.write ? '0 : rd_word;
    end
    if (wr) begin
      case (cmd.index)
        cprg_pkg::IDX_PWR: begin
          // Status byte is never stored, so written values cannot reach it
          st_nxt.pd_ctrl = cmd.wdata & cprg_pkg::PD_CTRL_MASK;
        end
        cprg_pkg::IDX_EXT_CTRL: begin
          st_nxt.var_rate = cmd.wdata[cprg_pkg::VR_BIT];
        end
        cprg_pkg::IDX_DAC_RATE: begin
          st_nxt.dac_rate = st_r.var_rate ? cprg_pkg::cprg_snap_rate(cmd.wdata)
                                          : cprg_pkg::RATE_RESET;
        end
        cprg_pkg::IDX_ADC_RATE: begin
          st_nxt.adc_rate = st_r.var_rate ? cprg_pkg::cprg_snap_rate(cmd.wdata)
                                          : cprg_pkg::RATE_RESET;
        end
        cprg_pkg::IDX_GPIO_DATA: begin
          st_nxt.gpio_out = cmd.wdata[cprg_pkg::GPIO_W-1:0];
        end
        cprg_pkg::IDX_GPIO_DIR: begin
          st_nxt.gpio_dir = cmd.wdata[cprg_pkg::GPIO_W-1:0];
        end
        cprg_pkg::IDX_RISE_EN: begin
          st_nxt.rise_en = cmd.wdata & cprg_pkg::IRQ_MASK;
        end
        cprg_pkg::IDX_FALL_EN: begin
          st_nxt.fall_en = cmd.wdata & cprg_pkg::IRQ_MASK;
        end
        cprg_pkg::IDX_IRQ_STAT: begin
          st_nxt.irq_stat = st_r.irq_stat & ~(cmd.wdata & cprg_pkg::IRQ_MASK);
        end
        default: begin
          st_nxt.pd_ctrl = st_r.pd_ctrl;
        end
      endcase
    end
    // A new edge in the clearing cycle wins over the clear
    st_nxt.irq_stat = st_nxt.irq_stat | hits;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r          <= '0;
      st_r.dac_rate <= cprg_pkg::RATE_RESET;
      st_r.adc_rate <= cprg_pkg::RATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign internal_clock_off_o      = st_r.pd_ctrl[cprg_pkg::PD_CLK_OFF];
  assign link_powerdown_o          = st_r.pd_ctrl[cprg_pkg::PD_LINK];
  assign audio_bias_powerdown_o    = st_r.pd_ctrl[cprg_pkg::PD_BIAS];
  assign playback_path_powerdown_o = st_r.pd_ctrl[cprg_pkg::PD_PLAY];
  assign record_path_powerdown_o   = st_r.pd_ctrl[cprg_pkg::PD_REC];
  assign variable_rate_enable_o    = st_r.var_rate;
  assign playback_rate_value_o     = dac_eff;
  assign record_rate_value_o       = adc_eff;
  assign gpio_pin_bits_o           = st_r.gpio_out;
  assign gpio_output_bits_o        = st_r.gpio_dir;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  pd_write_a: assert property (wr && cmd.index == cprg_pkg::IDX_PWR |=>
    internal_clock_off_o == $past(cmd.wdata[13]) && link_powerdown_o == $past(cmd.wdata[12]))
    else $error("clock or link power-down bit not taken from write");
  pd_paths_a: assert property (wr && cmd.index == cprg_pkg::IDX_PWR |=>
    {audio_bias_powerdown_o, playback_path_powerdown_o, record_path_powerdown_o}
      == {$past(cmd.wdata[11]), $past(cmd.wdata[9]), $past(cmd.wdata[8])})
    else $error("path power-down bits not taken from write");
  pd_status_a: assert property (fire && !cmd.write && cmd.index == cprg_pkg::IDX_PWR
    |=> st_r.rdata[7:0] == {4'h0, $past(sts_s[2]), 1'b0, $past(sts_s[1:0])})
    else $error("status byte does not show readiness");
  ready_time_a: assert property ($rose(st_r.ready) |-> $past(st_r.init_cnt) == 4'h3)
    else $error("ready raised at wrong time");
  ext_id_a: assert property (fire && !cmd.write && cmd.index == cprg_pkg::IDX_EXT_ID
    |=> st_r.rdata == 16'h0001)
    else $error("capability read wrong");
  fixed_rate_a: assert property (!variable_rate_enable_o |->
    playback_rate_value_o == 16'hbb80 && record_rate_value_o == 16'hbb80)
    else $error("rate not 48000 with variable rate off");
  snap_tie_a: assert property (wr && st_r.var_rate && cmd.wdata == 16'h36b0
    && cmd.index == cprg_pkg::IDX_DAC_RATE |=> playback_rate_value_o == 16'h3e80)
    else $error("tie did not snap to higher rate");
  rate_indep_a: assert property (wr && cmd.index == cprg_pkg::IDX_DAC_RATE
    |=> $stable(record_rate_value_o))
    else $error("record rate moved on playback write");
  gpio_drive_a: assert property (wr && cmd.index == cprg_pkg::IDX_GPIO_DATA
    |=> gpio_pin_bits_o == $past(cmd.wdata[9:0]))
    else $error("pin data not driven");
  irq_latch_a: assert property (hits != '0 |=> (st_r.irq_stat & $past(hits)) == $past(hits))
    else $error("enabled edge not latched");
  irq_clear_a: assert property (wr && cmd.index == cprg_pkg::IDX_IRQ_STAT && hits == '0
    |=> (st_r.irq_stat & $past(cmd.wdata)) == '0)
    else $error("write one did not clear status");
  rsvd_zero_a: assert property ((st_r.rise_en[10] | st_r.fall_en[10] | st_r.irq_stat[10]) == 1'b0)
    else $error("reserved bit set");

  rate_snap_c: cover property (wr && st_r.var_rate && cmd.index == cprg_pkg::IDX_ADC_RATE);
  irq_set_c:   cover property (hits != '0 ##[1:100] wr && cmd.index == cprg_pkg::IDX_IRQ_STAT);
  pin_read_c:  cover property (fire && !cmd.write && cmd.index == cprg_pkg::IDX_GPIO_DATA);
  ready_c:     cover property ($rose(st_r.ready));
endmodule

//--- rtl/cprg_pkg.sv
package cprg_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int IDX_W  = 7;
  localparam int DATA_W = 16;
  localparam int GPIO_W = 10;
  localparam int SRC_W  = 5;
  localparam int STS_W  = 3;
  localparam int N_RATES = 9;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_PWR       = 7'h26;
  localparam logic [IDX_W-1:0] IDX_EXT_ID    = 7'h28;
  localparam logic [IDX_W-1:0] IDX_EXT_CTRL  = 7'h2a;
  localparam logic [IDX_W-1:0] IDX_DAC_RATE  = 7'h2c;
  localparam logic [IDX_W-1:0] IDX_ADC_RATE  = 7'h32;
  localparam logic [IDX_W-1:0] IDX_GPIO_DATA = 7'h5a;
  localparam logic [IDX_W-1:0] IDX_GPIO_DIR  = 7'h5c;
  localparam logic [IDX_W-1:0] IDX_RISE_EN   = 7'h5e;
  localparam logic [IDX_W-1:0] IDX_FALL_EN   = 7'h60;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT  = 7'h62;

  // ----------------------------------------------------------------
  // Field positions, masks and reset values
  // ----------------------------------------------------------------
  localparam int PD_CLK_OFF = 13;
  localparam int PD_LINK    = 12;
  localparam int PD_BIAS    = 11;
  localparam int PD_PLAY    = 9;
  localparam int PD_REC     = 8;
  localparam int ST_REF     = 3;
  localparam int ST_DAC     = 1;
  localparam int ST_ADC     = 0;
  localparam int VR_BIT     = 0;
  localparam int SRC_LSB    = 11;
  localparam logic [DATA_W-1:0] PD_CTRL_MASK = 16'h3b00;
  localparam logic [DATA_W-1:0] IRQ_MASK     = 16'hfbff;
  localparam logic [DATA_W-1:0] EXT_ID_VALUE = 16'h0001;
  localparam logic [DATA_W-1:0] RATE_RESET   = 16'hbb80;
  localparam logic [3:0]        INIT_CYCLES  = 4'h4;
  localparam logic [DATA_W-1:0] RATE_TABLE [N_RATES] = '{
    16'h1f40, 16'h2b11, 16'h2ee0, 16'h3e80, 16'h5622,
    16'h5dc0, 16'h7d00, 16'hac44, 16'hbb80};

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              write;
    logic [IDX_W-1:0]  index;
    logic [DATA_W-1:0] wdata;
  } cprg_cmd_s;

  // Nearest supported rate, higher one on a tie
  function automatic logic [DATA_W-1:0] cprg_snap_rate(input logic [DATA_W-1:0] v);
    logic [DATA_W-1:0] r;
    logic [DATA_W:0]   thr;
    r = RATE_TABLE[0];
    for (int i = 1; i < N_RATES; i++) begin
      thr = 17'(({1'b0, RATE_TABLE[i-1]} + {1'b0, RATE_TABLE[i]} + 17'h0_0001) >> 1);
      if ({1'b0, v} >= thr) begin
        r = RATE_TABLE[i];
      end
    end
    return r;
  endfunction

endpackage

//--- tb/cprg_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Link host model, one command outstanding at a time
// ------------------------------------------------------------------
module cprg_host_model (
  // Link clock
  input  wire logic                link_clk_i,
  // Answer from device
  input  wire logic                rsp_valid_i,
  input  wire logic [15:0]         rsp_data_i,
  // Command to device
  output logic                     cmd_valid_o,
  output cprg_pkg::cprg_cmd_s      cmd_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_o = '0;
  end
  // Gap lets a caller act as a prompt or a slow host
  task automatic access(input logic wr, input logic [6:0] idx, input logic [15:0] wd,
                        input int gap, output logic [15:0] rd, output logic ok);
    ok = 1'b0;
    repeat (gap + 1) @(negedge link_clk_i);
    cmd_valid_o = 1'b1;
    cmd_o = {wr, idx, wd};
    @(negedge link_clk_i);
    cmd_valid_o = 1'b0;
    // Released bus shows the inverse, so stale data cannot pass for a match
    cmd_o = ~cmd_o;
    for (int n = 0; n < 40 && !ok; n++) begin
      @(negedge link_clk_i);
      ok = (rsp_valid_i === 1'b1);
    end
    rd = rsp_data_i;
  endtask
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------------
  // Clocks, pins and instances
  // ----------------------------------------------------------------
  logic                core_clk_i = 1'b0;
  logic                link_clk_i = 1'b0;
  logic                rst_b_i = 1'b0;
  logic                rv;
  logic                cv;
  logic                rdy;
  logic                vr_en;
  logic [15:0]         rd;
  logic [15:0]         prate;
  logic [15:0]         rrate;
  cprg_pkg::cprg_cmd_s cmd;
  logic [2:0]          ready = 3'b101;
  logic [4:0]          src = 5'h00;
  logic [4:0]          pd;
  logic [9:0]          ext = 10'h005;
  logic [9:0]          pin_o;
  logic [9:0]          dir_o;
  logic [9:0]          pins;
  int                  fail_count = 0;
  int                  comparisons = 0;
  logic [15:0] wv [14] = '{16'h1f40, 16'h2b11, 16'h2ee0, 16'h3e80, 16'h5622, 16'h5dc0,
    16'h7d00, 16'hac44, 16'hbb80, 16'h36b0, 16'h36af, 16'h6d60, 16'h0000, 16'hffff};
  logic [15:0] ev [14] = '{16'h1f40, 16'h2b11, 16'h2ee0, 16'h3e80, 16'h5622, 16'h5dc0,
    16'h7d00, 16'hac44, 16'hbb80, 16'h3e80, 16'h2ee0, 16'h7d00, 16'h1f40, 16'hbb80};
  initial forever #5 core_clk_i = ~core_clk_i;
  initial begin
    #3;
    forever #7.5 link_clk_i = ~link_clk_i;
  end
  // Pins not driven by the block take the outside level
  assign pins = (dir_o & pin_o) | (~dir_o & ext);
  cprg_regs u_dut (.core_clk_i(core_clk_i), .link_clk_i(link_clk_i), .rst_b_i(rst_b_i),
    .slot_cmd_valid_i(cv), .slot_cmd_i(cmd), .slot_rsp_valid_o(rv), .slot_rsp_data_o(rd),
    .codec_ready_o(rdy), .bias_ready_i(ready[2]), .playback_ready_i(ready[1]),
    .record_ready_i(ready[0]), .internal_clock_off_o(pd[4]), .link_powerdown_o(pd[3]),
    .audio_bias_powerdown_o(pd[2]), .playback_path_powerdown_o(pd[1]),
    .record_path_powerdown_o(pd[0]), .variable_rate_enable_o(vr_en),
    .playback_rate_value_o(prate), .record_rate_value_o(rrate), .gpio_pin_bits_i(pins),
    .gpio_pin_bits_o(pin_o), .gpio_output_bits_o(dir_o), .overflow_signal_i(src[4]),
    .clipping_signal_i(src[3]), .touch_minus_comparator_i(src[2]),
    .touch_plus_comparator_i(src[1]), .conversion_done_i(src[0]));
  cprg_host_model u_host (.link_clk_i(link_clk_i), .rsp_valid_i(rv), .rsp_data_i(rd),
    .cmd_valid_o(cv), .cmd_o(cmd));
  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] idx, input logic [15:0] d);
    logic [15:0] r;
    logic        ok;
    u_host.access(1'b1, idx, d, 0, r, ok);
    chk("write answer", 16'h0000, ok ? r : 16'hxxxx);
  endtask
  task automatic rd_chk(input logic [6:0] idx, input logic [15:0] exp, input string nm);
    logic [15:0] r;
    logic        ok;
    u_host.access(1'b0, idx, 16'h0000, 2, r, ok);
    chk(nm, exp, ok ? r : 16'hxxxx);
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(negedge core_clk_i);
    rst_b_i = 1'b1;
    chk("early ready", 16'h0000, {15'h0000, rdy});
    for (int n = 0; n < 100 && rdy !== 1'b1; n++) @(negedge link_clk_i);
    chk("codec ready", 16'h0001, {15'h0000, rdy});
    rd_chk(cprg_pkg::IDX_PWR, 16'h0009, "power status");
    rd_chk(cprg_pkg::IDX_EXT_ID, 16'h0001, "capability");
    rd_chk(cprg_pkg::IDX_DAC_RATE, 16'hbb80, "playback reset");
    rd_chk(cprg_pkg::IDX_ADC_RATE, 16'hbb80, "record reset");
    wr(cprg_pkg::IDX_PWR, 16'hffff);
    @(negedge core_clk_i);
    ready = 3'b010;
    rd_chk(cprg_pkg::IDX_PWR, 16'h3b02, "power control");
    chk("power outputs", 16'h001f, {11'h000, pd});
    wr(cprg_pkg::IDX_PWR, 16'h2000);
    chk("clock off only", 16'h0010, {11'h000, pd});
    wr(cprg_pkg::IDX_EXT_ID, 16'hffff);
    rd_chk(cprg_pkg::IDX_EXT_ID, 16'h0001, "capability kept");
    wr(cprg_pkg::IDX_DAC_RATE, 16'h1f40);
    rd_chk(cprg_pkg::IDX_DAC_RATE, 16'hbb80, "fixed rate");
    wr(cprg_pkg::IDX_EXT_CTRL, 16'hffff);
    rd_chk(cprg_pkg::IDX_EXT_CTRL, 16'h0001, "rate mode");
    chk("rate mode out", 16'h0001, {15'h0000, vr_en});
    for (int i = 0; i < 14; i++) begin
      wr(cprg_pkg::IDX_DAC_RATE, wv[i]);
      wr(cprg_pkg::IDX_ADC_RATE, wv[13-i]);
      rd_chk(cprg_pkg::IDX_DAC_RATE, ev[i], "playback rate");
      rd_chk(cprg_pkg::IDX_ADC_RATE, ev[13-i], "record rate");
      chk("playback output", ev[i], prate);
    end
    wr(cprg_pkg::IDX_EXT_CTRL, 16'h0000);
    chk("record output fixed", 16'hbb80, rrate);
    wr(cprg_pkg::IDX_GPIO_DIR, 16'hfcf0);
    rd_chk(cprg_pkg::IDX_GPIO_DIR, 16'h00f0, "direction");
    chk("output enables", 16'h00f0, {6'h00, dir_o});
    wr(cprg_pkg::IDX_GPIO_DATA, 16'hffff);
    rd_chk(cprg_pkg::IDX_GPIO_DATA, 16'h00f5, "pin levels");
    wr(cprg_pkg::IDX_RISE_EN, 16'hffff);
    rd_chk(cprg_pkg::IDX_RISE_EN, 16'hfbff, "rise enables");
    wr(cprg_pkg::IDX_FALL_EN, 16'hffff);
    rd_chk(cprg_pkg::IDX_FALL_EN, 16'hfbff, "fall enables");
    wr(cprg_pkg::IDX_FALL_EN, 16'h0000);
    @(negedge core_clk_i);
    src = 5'h1f;
    ext = 10'h30f;
    rd_chk(cprg_pkg::IDX_IRQ_STAT, 16'hfb0a, "rise status");
    wr(cprg_pkg::IDX_IRQ_STAT, 16'hffff);
    rd_chk(cprg_pkg::IDX_IRQ_STAT, 16'h0000, "status cleared");
    wr(cprg_pkg::IDX_RISE_EN, 16'h0000);
    @(negedge core_clk_i);
    src = 5'h00;
    ext = 10'h000;
    repeat (6) @(negedge core_clk_i);
    src = 5'h1f;
    ext = 10'h30f;
    rd_chk(cprg_pkg::IDX_IRQ_STAT, 16'h0000, "masked edges");
    wr(7'h10, 16'hffff);
    rd_chk(7'h10, 16'h0000, "unmapped");
    close_out();
  end
  initial begin
    #100000;
    fail_count++;
    close_out();
  end
endmodule
